// [adsc_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adsc_analog_model
(
  // front end side
  input wire logic clk_sys,
  input wire logic [2:0] analog_mux_sel,
  input wire logic conv_enable,
  input wire logic conv_reset,
  input wire logic [11:0] level,
  output logic [11:0] conv_data
);
  initial conv_data = 12'h5A5;
  // code settles only while converting; toggling otherwise so stale data never matches
  always @(posedge clk_sys)
  begin
    if (conv_enable && !conv_reset)
      conv_data <= {level[11:3], analog_mux_sel};
    else
      conv_data <= ~conv_data;
  end
endmodule : adsc_analog_model
`default_nettype wire

// [adsc_pkg.sv]
// ****************************************************************
// constants for the converter sequencing control
// ****************************************************************
package adsc_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADSC_OFF_CTRL = 3'h0; // converter_control_reg
  localparam logic [2:0] ADSC_OFF_CLKSEL = 3'h1; // converter_clock_select_reg
  localparam logic [2:0] ADSC_OFF_RES_LO = 3'h2; // conversion_result_low
  localparam logic [2:0] ADSC_OFF_RES_HI = 3'h3; // conversion_result_high
  localparam logic [2:0] ADSC_OFF_STATUS = 3'h4; // interrupt request flag and enable
  // control register fields
  localparam int ADSC_CTRL_START_POS = 7;
  localparam int ADSC_CTRL_EOC_POS = 6;
  localparam int ADSC_CTRL_PCR_POS = 3;
  localparam int ADSC_CTRL_CH_POS = 0;
  // clock select register fields
  localparam int ADSC_CLK_POFF_POS = 7;
  localparam int ADSC_CLK_DIV_POS = 0;
  // status register fields
  localparam int ADSC_ST_IRQF_POS = 0;
  localparam int ADSC_ST_IEN_POS = 1;
  // reset values
  localparam logic [7:0] ADSC_CTRL_RST = 8'h40; // eoc flag high, pins digital
  localparam logic [7:0] ADSC_CLK_RST = 8'h80; // converter powered off
  localparam logic [11:0] ADSC_RES_RST = 12'h000;
  // pin configuration codes
  localparam logic [2:0] ADSC_PCR_OFF = 3'h0;
  localparam logic [2:0] ADSC_PCR_ALL = 3'h7;
  // conversion clock divider codes and ratios
  localparam logic [2:0] ADSC_DIV2 = 3'h0;
  localparam logic [2:0] ADSC_DIV8 = 3'h1;
  localparam logic [2:0] ADSC_DIV32 = 3'h2;
  localparam logic [5:0] ADSC_HALF_DIV2 = 6'h01;
  localparam logic [5:0] ADSC_HALF_DIV8 = 6'h04;
  localparam logic [5:0] ADSC_HALF_DIV32 = 6'h10;
  // conversion length in conversion clock periods
  localparam logic [4:0] ADSC_CONV_PERIODS = 5'h10;
  typedef enum logic [1:0] {
    ADSC_IDLE = 2'b00,
    ADSC_RESET = 2'b01,
    ADSC_CONV = 2'b10
  } adsc_state_type;
endpackage : adsc_pkg

// [adsc_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker for the sequencing control
// ****************************************
module adsc_props
  import adsc_pkg::*;
(
  // clock, reset and register port
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and front end
  input wire logic [7:0] port_direction_control,
  input wire logic [7:0] port_pullup_en,
  input wire logic [7:0] pin_analog_en,
  input wire logic [7:0] pin_dir_input,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [2:0] analog_mux_sel,
  input wire logic conv_enable,
  input wire logic conv_reset,
  input wire logic conv_sample
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // start pulse steps; the clear keeps pins analog so the converter stays on
  sequence s_arm;
    reg_wr && reg_addr == ADSC_OFF_CTRL && reg_wdata[7] && conv_enable;
  endsequence
  sequence s_go;
    reg_wr && reg_addr == ADSC_OFF_CTRL && !reg_wdata[7] && reg_wdata[5:3] != 3'h0;
  endsequence
  a_dir_override: assert property (pin_dir_input == (port_direction_control | pin_analog_en))
    else $error("direction not overridden");
  a_pullup_cut: assert property (pin_pullup_en == (port_pullup_en & ~pin_analog_en))
    else $error("pull-up left on analog pin");
  a_enable_pins: assert property (conv_enable |-> pin_analog_en != 8'h00)
    else $error("converter on with no analog pin");
  a_pcr_all: assert property (reg_wr && reg_addr == ADSC_OFF_CTRL && reg_wdata[5:3] == ADSC_PCR_ALL
    |=> pin_analog_en == 8'hFF) else $error("not all pins analog");
  a_pcr_off: assert property (reg_wr && reg_addr == ADSC_OFF_CTRL && reg_wdata[5:3] == ADSC_PCR_OFF
    |=> pin_analog_en == 8'h00 && !conv_enable) else $error("pins not digital");
  a_mux_follow: assert property (reg_wr && reg_addr == ADSC_OFF_CTRL
    |=> analog_mux_sel == $past(reg_wdata[2:0])) else $error("wrong channel routed");
  a_start_holds: assert property (s_arm |=> conv_reset) else $error("reset not held");
  a_start_runs: assert property (s_arm ##[1:8] s_go |=> ##1 !conv_reset)
    else $error("conversion did not begin");
  a_sample_pulse: assert property (conv_sample |=> !conv_sample) else $error("sample too long");
  a_low_nibble: assert property (reg_rd && reg_addr == ADSC_OFF_RES_LO |=> reg_rdata[3:0] == 4'h0)
    else $error("low nibble not zero");
endmodule : adsc_props
bind adsc_top adsc_props u_props (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .port_direction_control, .port_pullup_en, .pin_analog_en, .pin_dir_input,
  .pin_pullup_en, .analog_mux_sel, .conv_enable, .conv_reset, .conv_sample);
`default_nettype wire

// [adsc_sequencing_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module adsc_sequencing_control_tb_top;
  import adsc_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0, analog_mux_sel;
  logic [7:0] reg_wdata = 8'h00, port_direction_control = 8'h00, port_pullup_en = 8'h00;
  logic [7:0] reg_rdata, pin_analog_en, pin_dir_input, pin_pullup_en;
  logic conv_enable, conv_reset, conv_sample, conv_irq;
  logic [11:0] level = 12'h000, conv_data;
  int fails = 0, n_tests = 0;
  always #50 clk_sys = ~clk_sys;
  adsc_top dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_direction_control, .port_pullup_en, .pin_analog_en, .pin_dir_input, .pin_pullup_en,
    .analog_mux_sel, .conv_enable, .conv_reset, .conv_sample, .conv_data, .conv_irq);
  adsc_analog_model u_model (.clk_sys, .analog_mux_sel, .conv_enable, .conv_reset, .level,
    .conv_data);
  // ****************************************
  // checks and bus cycles
  // ****************************************
  task wrap_up;
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so look at the next low phase
  task rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(16'(reg_rdata & m), 16'(e));
  endtask : rd
  // one full conversion; completion is timed on the rise of the converter reset
  task conv(input logic [2:0] ch, input logic [2:0] pcr, input logic [2:0] dv, input logic ien);
    int n;
    logic [11:0] r;
    @(posedge clk_sys);
    level <= 12'($urandom);
    port_direction_control <= 8'($urandom);
    port_pullup_en <= 8'($urandom);
    wr(ADSC_OFF_STATUS, {6'h00, ien, 1'b0});
    wr(ADSC_OFF_CLKSEL, {5'h00, dv});
    wr(ADSC_OFF_CTRL, {2'b10, pcr, ch});
    rd(ADSC_OFF_CTRL, 8'h7F, {2'b01, pcr, ch});
    wr(ADSC_OFF_CTRL, {2'b00, pcr, ch});
    // reset drops one edge after the start clear; count from there to its rise
    n = 0;
    while (n < 20 && conv_reset !== 1'b0)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20)
    begin
      fails++;
      wrap_up();
    end
    n = 0;
    while (n < 2000 && conv_reset !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 2000)
    begin
      fails++;
      wrap_up();
    end
    chk(16'(n), 16'(32 * (1 << (2 * dv))));
    chk(16'(conv_irq), 16'(ien));
    r = {level[11:3], ch};
    wr(ADSC_OFF_RES_LO, 8'hFF);
    rd(ADSC_OFF_STATUS, 8'h01, 8'h01);
    rd(ADSC_OFF_CTRL, 8'h40, 8'h00);
    rd(ADSC_OFF_RES_HI, 8'hFF, r[11:4]);
    rd(ADSC_OFF_RES_LO, 8'hFF, {r[3:0], 4'h0});
    wr(ADSC_OFF_STATUS, {6'h00, ien, 1'b0});
    @(negedge clk_sys);
    chk(16'(conv_irq), 16'h0000);
  endtask : conv
  // ****************************************
  // main sequence and hang guard
  // ****************************************
  initial
  begin
    void'($urandom(35666));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADSC_OFF_CTRL, 8'hFF, ADSC_CTRL_RST);
    rd(ADSC_OFF_CLKSEL, 8'hFF, ADSC_CLK_RST);
    rd(ADSC_OFF_RES_HI, 8'hFF, 8'h00);
    rd(3'h5, 8'hFF, 8'h00);
    chk(16'(conv_enable), 16'h0000);
    for (int i = 0; i < 6; i++)
      conv(3'($urandom), (i == 0) ? ADSC_PCR_ALL : 3'(1 + $urandom % 7), 3'(1 + i % 2), i[0]);
    wr(ADSC_OFF_CLKSEL, 8'h80);
    @(negedge clk_sys);
    chk(16'(conv_enable), 16'h0000);
    wr(ADSC_OFF_CTRL, 8'h00);
    @(negedge clk_sys);
    chk(16'(pin_analog_en), 16'h0000);
    wrap_up();
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end
endmodule : adsc_sequencing_control_tb_top
`default_nettype wire

// [adsc_top.sv]
// What this block does
// RL1 - one converter, eight selectable inputs, twelve-bit results
// RL2 - upper eight result bits in high byte, lower four in low byte top nibble
// RL3 - three-bit channel select routes exactly one input to the converter
// RL4 - pin configuration 111 makes all eight shared pins analog
// RL5 - pin configuration zero keeps pins digital and powers converter down
// RL6 - converter on only when configuration non-zero and power-off bit clear
// RL7 - start low, high, low begins a conversion
// RL8 - while start is high, converter held in reset and flag forced high
// RL9 - hardware clears end-of-conversion flag when conversion completes
// RL10 - completion sets request flag; interrupt raised only when enabled
// RL11 - software may poll end-of-conversion flag low instead of interrupts
// RL12 - divider select 000 gives /2, 001 /8, 010 /32, others undefined
// RL13 - software avoids /2 above 4 MHz system clock
// RL14 - pull-up disconnected on any pin configured analog
// RL15 - analog configuration overrides the port direction control
// RL16 - pin function switchable at run time through the configuration field
// RL17 - software pulses start soon after changing the channel select
// RL18 - channel change without pulse leaves flag undefined; pulse leaves it high
// RL19 - conversion lasts sixteen conversion clock periods
// RL20 - no pulse needed when channel select goes to zero
// RL21 - result bytes hold until the next conversion completes
// RL22 - both result bytes and flag clear update in the same cycle
`timescale 1ns/1ps
`default_nettype none
module adsc_top
  import adsc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // shared port pins
  input wire logic [7:0] port_direction_control,
  input wire logic [7:0] port_pullup_en,
  output logic [7:0] pin_analog_en,
  output logic [7:0] pin_dir_input,
  output logic [7:0] pin_pullup_en,
  // analog front end
  output logic [2:0] analog_mux_sel,
  output logic conv_enable,
  output logic conv_reset,
  output logic conv_sample,
  input wire logic [11:0] conv_data,
  // interrupt request
  output logic conv_irq
);
  import adsc_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic start_r;
  logic eoc_r;
  logic [2:0] pcr_r;
  logic [2:0] chan_r;
  logic poff_r;
  logic [2:0] div_r;
  logic irqf_r;
  logic ien_r;
  logic [11:0] result_r;
  logic [7:0] rdata_r;
  adsc_state_type state_r;
  logic [5:0] div_cnt_r;
  logic [4:0] period_cnt_r;
  logic tick;
  logic done;
  logic wr_ctrl;
  logic start_wr;
  logic [5:0] half_div;

  // ratio decode; unlisted codes fall back to /32, slowest is the safe choice
  function automatic logic [5:0] half_of(input logic [2:0] sel);
    case (sel)
      ADSC_DIV2: half_of = ADSC_HALF_DIV2; // see RL12
      ADSC_DIV8: half_of = ADSC_HALF_DIV8;
      default: half_of = ADSC_HALF_DIV32;
    endcase
  endfunction : half_of

  assign wr_ctrl = reg_wr && (reg_addr == ADSC_OFF_CTRL);
  assign start_wr = reg_wdata[ADSC_CTRL_START_POS];
  assign half_div = half_of(div_r);

  // ****************************************************************
  // control and clock select registers
  // ****************************************************************
  // software fields; pin function may change at any time
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      start_r <= ADSC_CTRL_RST[ADSC_CTRL_START_POS];
      pcr_r <= ADSC_CTRL_RST[ADSC_CTRL_PCR_POS +: 3];
      chan_r <= ADSC_CTRL_RST[ADSC_CTRL_CH_POS +: 3];
      poff_r <= ADSC_CLK_RST[ADSC_CLK_POFF_POS];
      div_r <= ADSC_CLK_RST[ADSC_CLK_DIV_POS +: 3];
      ien_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        start_r <= start_wr;
        pcr_r <= reg_wdata[ADSC_CTRL_PCR_POS +: 3]; // see RL16
        chan_r <= reg_wdata[ADSC_CTRL_CH_POS +: 3]; // see RL3
      end
      if (reg_wr && (reg_addr == ADSC_OFF_CLKSEL))
      begin
        poff_r <= reg_wdata[ADSC_CLK_POFF_POS];
        div_r <= reg_wdata[ADSC_CLK_DIV_POS +: 3];
      end
      if (reg_wr && (reg_addr == ADSC_OFF_STATUS))
        ien_r <= reg_wdata[ADSC_ST_IEN_POS];
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  // start high holds reset; its falling edge launches the conversion
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_r <= ADSC_IDLE;
    else if (!conv_enable)
      state_r <= ADSC_IDLE; // see RL6
    else if (start_r)
      state_r <= ADSC_RESET; // see RL8
    else
    begin
      unique case (state_r)
        ADSC_IDLE: state_r <= ADSC_IDLE;
        ADSC_RESET: state_r <= ADSC_CONV; // see RL7
        ADSC_CONV: state_r <= done ? ADSC_IDLE : ADSC_CONV;
        default: state_r <= ADSC_IDLE;
      endcase
    end
  end

  // conversion clock divider, restarted with each conversion
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      div_cnt_r <= 6'h00;
    else if (state_r != ADSC_CONV)
      div_cnt_r <= 6'h00;
    else if (tick)
      div_cnt_r <= 6'h00;
    else
      div_cnt_r <= div_cnt_r + 6'h01;
  end

  // a tick ends each full conversion clock period
  assign tick = (state_r == ADSC_CONV) && (div_cnt_r == ((half_div << 1) - 6'h01)); // see RL12

  // period counter over the conversion
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      period_cnt_r <= 5'h00;
    else if (state_r != ADSC_CONV)
      period_cnt_r <= 5'h00;
    else if (tick)
      period_cnt_r <= period_cnt_r + 5'h01;
  end

  assign done = tick && (period_cnt_r == (ADSC_CONV_PERIODS - 5'h01)); // see RL19

  // ****************************************************************
  // flag, request and result
  // ****************************************************************
  // flag forced high during the start pulse, cleared with the result load
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      eoc_r <= ADSC_CTRL_RST[ADSC_CTRL_EOC_POS];
    else if (start_r)
      eoc_r <= 1'b1; // see RL8, see RL18
    else if (done)
      eoc_r <= 1'b0; // see RL9, see RL22
  end

  // result captured only at completion, so it stands until the next one
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      result_r <= ADSC_RES_RST;
    else if (done)
      result_r <= conv_data; // see RL21, see RL22, see RL1
  end

  // sticky request; a completion in the clearing cycle wins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqf_r <= 1'b0;
    else if (done)
      irqf_r <= 1'b1; // see RL10
    else if (reg_wr && (reg_addr == ADSC_OFF_STATUS) && !reg_wdata[ADSC_ST_IRQF_POS])
      irqf_r <= 1'b0;
  end

  assign conv_irq = irqf_r && ien_r; // see RL10

  // ****************************************************************
  // read path
  // ****************************************************************
  // data valid in the cycle after the read strobe only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADSC_OFF_CTRL: rdata_r <= {start_r, eoc_r, pcr_r, chan_r};
        ADSC_OFF_CLKSEL: rdata_r <= {poff_r, 4'h0, div_r};
        ADSC_OFF_RES_LO: rdata_r <= {result_r[3:0], 4'h0}; // see RL2
        ADSC_OFF_RES_HI: rdata_r <= result_r[11:4]; // see RL2
        ADSC_OFF_STATUS: rdata_r <= {6'h00, ien_r, irqf_r};
        default: rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata = rdata_r;

  // ****************************************************************
  // pins and analog controls
  // ****************************************************************
  // codes 1..6 make pins 0..code analog, 7 makes all eight analog
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_analog_en[i] = (pcr_r == ADSC_PCR_ALL) || ((pcr_r != ADSC_PCR_OFF) && (i <= 32'(pcr_r))); // see RL4, see RL5
  end

  assign pin_dir_input = port_direction_control | pin_analog_en; // see RL15
  assign pin_pullup_en = port_pullup_en & ~pin_analog_en; // see RL14
  assign analog_mux_sel = chan_r; // see RL3
  assign conv_enable = (pcr_r != ADSC_PCR_OFF) && !poff_r; // see RL6, see RL5
  assign conv_reset = (state_r != ADSC_CONV); // see RL8
  assign conv_sample = tick;
endmodule : adsc_top
`default_nettype wire
